// ==== design/mfp_pin_map.sv ====
// Multifunction pin decoder for select codes 0x11 to 0x37.
// Assumes pins arrive asynchronously, internal flags on core_clk,
// and a one-cycle register port with read data one cycle later.
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
module mfp_pin_map #(
  parameter int N_PINS = 7,
  parameter int IRQ_W  = 8
) (
  // Clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         rst,
  // Register port
  input  wire logic [mfp_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [mfp_pkg::DATA_W-1:0]   reg_wr_data,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [mfp_pkg::DATA_W-1:0]   reg_rd_data,
  // Multifunction pins
  input  wire logic [N_PINS-1:0]            multifunction_pin_in,
  output logic      [N_PINS-1:0]            multifunction_pin_out,
  output logic      [N_PINS-1:0]            multifunction_pin_oe_n,
  // Internal interrupt events
  input  wire logic [IRQ_W-1:0]             common_irq_events,
  input  wire logic [IRQ_W-1:0]             channel_0_irq_events,
  input  wire logic [IRQ_W-1:0]             channel_1_irq_events,
  // Internal status images
  input  wire logic [7:0]                   resync_status_lo,
  input  wire logic [7:0]                   resync_status_hi,
  input  wire logic [mfp_pkg::NUM_REFS-1:0][7:0] ref_status,
  input  wire logic [mfp_pkg::NUM_REFS-1:0] ref_active,
  input  wire logic [7:0]                   digital_loop_0_active_status,
  input  wire logic [7:0]                   digital_loop_0_lock_status,
  input  wire logic [7:0]                   digital_loop_0_mode_status,
  // Control function outputs
  output logic                              clear_common_irq,
  output logic                              clear_channel_0_irq,
  output logic                              clear_channel_1_irq,
  output logic      [mfp_pkg::NUM_REFS-1:0] ref_force_fault,
  output logic      [mfp_pkg::NUM_REFS-1:0] ref_validation_timeout
);
  import mfp_pkg::*;

  // Readback registers hold one bit per pin, the combine register two, in a DATA_W word
  if (N_PINS < 1 || N_PINS > MAX_PINS) begin : g_bad_pins
    $error("mfp_pin_map: N_PINS must be 1 to 7");
  end
  if (IRQ_W < 1) begin : g_bad_irq
    $error("mfp_pin_map: IRQ_W must be at least 1");
  end

  // Configuration state
  logic [N_PINS-1:0][7:0]    func_reg;
  logic [N_PINS-1:0][1:0]    bool_reg;

  // Pin synchroniser and outputs
  logic [N_PINS-1:0]         pin_meta_reg;
  logic [N_PINS-1:0]         pin_sync_reg;
  logic [N_PINS-1:0]         pin_out_next;
  logic [N_PINS-1:0]         pin_out_reg;
  logic [N_PINS-1:0]         pin_oe_n_reg;

  // Decoded status and control
  logic [CODE_LAST:CODE_FIRST] status_vec;
  logic [NUM_CTRL-1:0]       ctrl_next;
  logic [NUM_CTRL-1:0]       ctrl_reg;
  logic [DATA_W-1:0]         rd_next;
  logic [DATA_W-1:0]         rd_data_reg;

  // Code carried by a pin
  function automatic logic [CODE_W-1:0] pin_code(input logic [7:0] fr);
    pin_code = fr[CODE_W-1:0];
  endfunction

  // Pin is a control input when its output enable bit is clear
  function automatic logic pin_is_ctrl(input logic [7:0] fr);
    pin_is_ctrl = ~fr[FUNC_OE_BIT];
  endfunction

  // Aggregate all control pins that carry one code
  function automatic logic combine(
    input logic [CODE_W-1:0]       code,
    input logic [N_PINS-1:0][7:0]  fr,
    input logic [N_PINS-1:0][1:0]  br,
    input logic [N_PINS-1:0]       lvl
  );
    logic any_pin;
    logic any_or;
    logic or_val;
    logic and_val;
    logic term;
    any_pin = 1'b0;
    any_or  = 1'b0;
    or_val  = 1'b0;
    and_val = 1'b1;
    term    = 1'b0;
    for (int i = 0; i < N_PINS; i++) begin
      if (pin_is_ctrl(fr[i]) && pin_code(fr[i]) == code) begin
        term    = lvl[i] ^ br[i][0];
        any_pin = 1'b1;
        if (br[i][1]) begin
          any_or = 1'b1;
          or_val = or_val | term;
        end else begin
          and_val = and_val & term;
        end
      end
    end
    // OR group collapses to one term before the AND stage
    combine = any_pin & and_val & (any_or ? or_val : 1'b1);
  endfunction

  // Two-flop synchroniser on the pads
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end else begin
      pin_meta_reg <= multifunction_pin_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Function registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < N_PINS; i++) begin
        func_reg[i] <= FUNC_RST;
      end
    end else if (reg_wr) begin
      for (int i = 0; i < N_PINS; i++) begin
        if (reg_addr == FUNC_BASE + 8'(i)) begin
          func_reg[i] <= reg_wr_data[7:0];
        end
      end
    end
  end

  // Combine code register, two bits per pin
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < N_PINS; i++) begin
        bool_reg[i] <= BOOL_RST;
      end
    end else if (reg_wr && reg_addr == BOOL_OFS) begin
      for (int i = 0; i < N_PINS; i++) begin
        bool_reg[i] <= reg_wr_data[2*i +: 2];
      end
    end
  end

  // Status sources, indexed by code; unlisted codes stay low
  always_comb begin
    status_vec = '0;
    status_vec[CODE_CLR_COMMON] = |common_irq_events;
    status_vec[CODE_CLR_CH0]    = |channel_0_irq_events;
    status_vec[CODE_CLR_CH1]    = |channel_1_irq_events;
    status_vec[CODE_RESYNC]        = resync_status_lo[RESYNC_LO_BIT];
    status_vec[CODE_RESYNC + 7'h1] = resync_status_lo[RESYNC_HI_BIT];
    status_vec[CODE_RESYNC + 7'h2] = resync_status_hi[RESYNC_LO_BIT];
    status_vec[CODE_RESYNC + 7'h3] = resync_status_hi[RESYNC_HI_BIT];
    for (int r = 0; r < NUM_REFS; r++) begin
      status_vec[CODE_FAULT + 7'(r)] = ref_status[r][REF_FAULT_BIT];
      status_vec[CODE_VALID + 7'(r)] = ref_status[r][REF_VALID_BIT];
      status_vec[CODE_VALTO + 7'(r)] = ref_active[r];
    end
    status_vec[CODE_PH_LOCK]   = digital_loop_0_lock_status[PH_LOCK_BIT];
    status_vec[CODE_FR_LOCK]   = digital_loop_0_lock_status[FR_LOCK_BIT];
    status_vec[CODE_AL_LOCK]   = digital_loop_0_lock_status[AL_LOCK_BIT];
    status_vec[CODE_AL_CAL]    = digital_loop_0_lock_status[AL_CAL_BIT];
    status_vec[CODE_ACTIVE]    = |digital_loop_0_active_status[ACTIVE_MSB:0];
    status_vec[CODE_FREERUN]   = digital_loop_0_mode_status[FREERUN_BIT];
    status_vec[CODE_HOLDOVER]  = digital_loop_0_mode_status[HOLDOVER_BIT];
    status_vec[CODE_SWITCHING] = digital_loop_0_mode_status[SWITCHING_BIT];
  end

  // Per-pin status select; codes outside the decoded span read low
  always_comb begin
    pin_out_next = '0;
    for (int i = 0; i < N_PINS; i++) begin
      if (!pin_is_ctrl(func_reg[i]) && pin_code(func_reg[i]) >= CODE_FIRST
          && pin_code(func_reg[i]) <= CODE_LAST) begin
        pin_out_next[i] = status_vec[pin_code(func_reg[i])];
      end
    end
  end

  // Registered pin drive keeps the pads free of mux glitches
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_out_reg  <= '0;
      pin_oe_n_reg <= '1;
    end else begin
      pin_out_reg <= pin_out_next;
      for (int i = 0; i < N_PINS; i++) begin
        pin_oe_n_reg[i] <= pin_is_ctrl(func_reg[i]);
      end
    end
  end

  // Control functions from the synchronised pin levels
  always_comb begin
    ctrl_next = '0;
    ctrl_next[CF_CLR_COMMON] = combine(CODE_CLR_COMMON, func_reg, bool_reg,
                                       pin_sync_reg);
    ctrl_next[CF_CLR_CH0]    = combine(CODE_CLR_CH0, func_reg, bool_reg,
                                       pin_sync_reg);
    ctrl_next[CF_CLR_CH1]    = combine(CODE_CLR_CH1, func_reg, bool_reg,
                                       pin_sync_reg);
    for (int r = 0; r < NUM_REFS; r++) begin
      ctrl_next[CF_FAULT + r] = combine(CODE_FAULT + 7'(r), func_reg, bool_reg,
                                        pin_sync_reg);
      // Validation ends early only for a reference that is faulted
      ctrl_next[CF_VALTO + r] = combine(CODE_VALTO + 7'(r), func_reg, bool_reg,
                                        pin_sync_reg)
                                & ref_status[r][REF_FAULT_BIT];
    end
  end

  // Control outputs are levels that follow the pins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  assign clear_common_irq       = ctrl_reg[CF_CLR_COMMON];
  assign clear_channel_0_irq    = ctrl_reg[CF_CLR_CH0];
  assign clear_channel_1_irq    = ctrl_reg[CF_CLR_CH1];
  assign ref_force_fault        = ctrl_reg[CF_FAULT +: NUM_REFS];
  assign ref_validation_timeout = ctrl_reg[CF_VALTO +: NUM_REFS];
  assign multifunction_pin_out  = pin_out_reg;
  assign multifunction_pin_oe_n = pin_oe_n_reg;

  // Read decode; unmapped addresses read zero
  always_comb begin
    rd_next = '0;
    for (int i = 0; i < N_PINS; i++) begin
      if (reg_addr == FUNC_BASE + 8'(i)) begin
        rd_next = {8'h00, func_reg[i]};
      end
    end
    if (reg_addr == BOOL_OFS) begin
      for (int i = 0; i < N_PINS; i++) begin
        rd_next[2*i +: 2] = bool_reg[i];
      end
    end
    if (reg_addr == STAT_OFS) begin
      rd_next[N_PINS-1:0] = pin_out_reg;
    end
    if (reg_addr == PIN_OFS) begin
      rd_next[N_PINS-1:0] = pin_sync_reg;
    end
    if (reg_addr == CTRL_OFS) begin
      rd_next[NUM_CTRL-1:0] = ctrl_reg;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_data_reg <= '0;
    end else if (reg_rd) begin
      rd_data_reg <= rd_next;
    end else begin
      rd_data_reg <= '0;
    end
  end

  assign reg_rd_data = rd_data_reg;

endmodule // mfp_pin_map

// ==== inc/mfp_pkg.sv ====
// Constants for the multifunction pin code decoder.
// Assumes one core clock domain and a plain register port.
package mfp_pkg;
  // Register port geometry
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 16;
  localparam int CODE_W   = 7;
  localparam int MAX_PINS = 7;

  // Register offsets
  localparam logic [7:0] FUNC_BASE = 8'h00;
  localparam logic [7:0] BOOL_OFS  = 8'h08;
  localparam logic [7:0] STAT_OFS  = 8'h09;
  localparam logic [7:0] PIN_OFS   = 8'h0a;
  localparam logic [7:0] CTRL_OFS  = 8'h0b;

  // Function register layout and reset values
  localparam int         FUNC_OE_BIT = 7;
  localparam logic [7:0] FUNC_RST    = 8'h00;
  localparam logic [1:0] BOOL_RST    = 2'h0;

  // Per-pin combine codes
  localparam logic [1:0] BOOL_AND  = 2'h0;
  localparam logic [1:0] BOOL_NAND = 2'h1;
  localparam logic [1:0] BOOL_OR   = 2'h2;
  localparam logic [1:0] BOOL_NOR  = 2'h3;

  // Function codes
  localparam logic [6:0] CODE_FIRST      = 7'h11;
  localparam logic [6:0] CODE_LAST       = 7'h37;
  localparam logic [6:0] CODE_CLR_COMMON = 7'h11;
  localparam logic [6:0] CODE_CLR_CH0    = 7'h12;
  localparam logic [6:0] CODE_CLR_CH1    = 7'h13;
  localparam logic [6:0] CODE_RESYNC     = 7'h1c;
  localparam logic [6:0] CODE_FAULT      = 7'h20;
  localparam logic [6:0] CODE_VALID      = 7'h24;
  localparam logic [6:0] CODE_VALTO      = 7'h28;
  localparam logic [6:0] CODE_PH_LOCK    = 7'h30;
  localparam logic [6:0] CODE_FR_LOCK    = 7'h31;
  localparam logic [6:0] CODE_AL_LOCK    = 7'h32;
  localparam logic [6:0] CODE_AL_CAL     = 7'h33;
  localparam logic [6:0] CODE_ACTIVE     = 7'h34;
  localparam logic [6:0] CODE_FREERUN    = 7'h35;
  localparam logic [6:0] CODE_HOLDOVER   = 7'h36;
  localparam logic [6:0] CODE_SWITCHING  = 7'h37;

  // Source bit positions inside the status images
  localparam int RESYNC_LO_BIT = 3;
  localparam int RESYNC_HI_BIT = 7;
  localparam int REF_FAULT_BIT = 3;
  localparam int REF_VALID_BIT = 4;
  localparam int PH_LOCK_BIT   = 1;
  localparam int FR_LOCK_BIT   = 2;
  localparam int AL_LOCK_BIT   = 3;
  localparam int AL_CAL_BIT    = 4;
  localparam int ACTIVE_MSB    = 5;
  localparam int FREERUN_BIT   = 0;
  localparam int HOLDOVER_BIT  = 1;
  localparam int SWITCHING_BIT = 2;

  // Control function slots
  localparam int NUM_CTRL      = 11;
  localparam int CF_CLR_COMMON = 0;
  localparam int CF_CLR_CH0    = 1;
  localparam int CF_CLR_CH1    = 2;
  localparam int CF_FAULT      = 3;
  localparam int CF_VALTO      = 7;
  localparam int NUM_REFS      = 4;
endpackage

// ==== dv/mfp_pin_map_properties.sv ====
// Port assertions for the pin decoder; mirrors the pin 0 function register.
// Assumes a bind into mfp_pin_map, one core clock and a sync reset.
`timescale 1ns/1ns
module mfp_pin_map_properties #(
  parameter int N_PINS = 7,
  parameter int IRQ_W  = 8
) (
  // Clock, reset and register port
  input wire logic                         core_clk,
  input wire logic                         rst,
  input wire logic [mfp_pkg::ADDR_W-1:0]   reg_addr,
  input wire logic [mfp_pkg::DATA_W-1:0]   reg_wr_data,
  input wire logic                         reg_wr,
  input wire logic                         reg_rd,
  input wire logic [mfp_pkg::DATA_W-1:0]   reg_rd_data,
  // Pads and sources
  input wire logic [N_PINS-1:0]            multifunction_pin_out,
  input wire logic [N_PINS-1:0]            multifunction_pin_oe_n,
  input wire logic [IRQ_W-1:0]             common_irq_events,
  input wire logic [IRQ_W-1:0]             channel_0_irq_events,
  input wire logic [7:0]                   resync_status_lo,
  input wire logic [mfp_pkg::NUM_REFS-1:0][7:0] ref_status,
  // Control outputs
  input wire logic                         clear_common_irq,
  input wire logic [mfp_pkg::NUM_REFS-1:0] ref_force_fault,
  input wire logic [mfp_pkg::NUM_REFS-1:0] ref_validation_timeout
);
  import mfp_pkg::*;
  logic [7:0] sh0_reg;
  // Updates on the same edge as the design's own register
  always_ff @(posedge core_clk) begin
    if (rst) sh0_reg <= FUNC_RST;
    else if (reg_wr && reg_addr == FUNC_BASE) sh0_reg <= reg_wr_data[7:0];
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_rd0;
    reg_rd && reg_addr == FUNC_BASE;
  endsequence
  // Guard on rst keeps pre-reset history out of the comparison
  sequence s_stat(logic [7:0] v);
    !$past(rst) && $past(sh0_reg) == v;
  endsequence
  a_rd_idle_zero: assert property (!$past(reg_rd) |-> reg_rd_data == '0)
    else $error("read data seen outside its cycle");
  a_rd_func_back: assert property (s_rd0 |=> reg_rd_data == {8'h00, $past(sh0_reg)})
    else $error("function register read back wrong");
  a_oe_mode_bit: assert property (!$past(rst) |->
    multifunction_pin_oe_n[0] == !$past(sh0_reg[FUNC_OE_BIT]))
    else $error("pin drive enable does not follow mode bit");
  a_common_status: assert property (s_stat(8'h91) |->
    multifunction_pin_out[0] == $past(|common_irq_events))
    else $error("common event status wrong");
  a_ch0_status: assert property (s_stat(8'h92) |->
    multifunction_pin_out[0] == $past(|channel_0_irq_events))
    else $error("channel 0 event status wrong");
  a_resync_status: assert property (s_stat(8'h9c) |->
    multifunction_pin_out[0] == $past(resync_status_lo[RESYNC_LO_BIT]))
    else $error("resync status wrong");
  a_unassigned_low: assert property (!$past(rst) && $past(sh0_reg[7]) &&
    $past(sh0_reg[6:0]) inside {[7'h14:7'h1b]} |-> !multifunction_pin_out[0])
    else $error("unassigned status code not low");
  a_ctrl_quiet: assert property (multifunction_pin_oe_n == '0 [*2] |->
    !clear_common_irq && ref_force_fault == '0)
    else $error("control output active with all pins in status mode");
  a_valto_gated: assert property (ref_validation_timeout[0] |->
    $past(ref_status[0][REF_FAULT_BIT]))
    else $error("validation timeout without fault");
endmodule // mfp_pin_map_properties

bind mfp_pin_map mfp_pin_map_properties #(.N_PINS(N_PINS), .IRQ_W(IRQ_W)) u_props (
  .core_clk, .rst, .reg_addr, .reg_wr_data, .reg_wr, .reg_rd, .reg_rd_data,
  .multifunction_pin_out, .multifunction_pin_oe_n, .common_irq_events,
  .channel_0_irq_events, .resync_status_lo, .ref_status, .clear_common_irq,
  .ref_force_fault, .ref_validation_timeout);

// ==== dv/mfp_far_end.sv ====
// Far-end logic on the multifunction pads.
// Assumes push-pull pads; a pad the device drives shows the device level.
`timescale 1ns/1ns
module mfp_far_end #(
  parameter int N_PINS = 7
) (
  // Bench control levels
  input  wire logic [N_PINS-1:0] drv,
  // Device pad side
  input  wire logic [N_PINS-1:0] pin_out,
  input  wire logic [N_PINS-1:0] pin_oe_n,
  output logic      [N_PINS-1:0] pad
);
  // Drives only pads the device has released
  always_comb begin
    for (int i = 0; i < N_PINS; i++) pad[i] = pin_oe_n[i] ? drv[i] : pin_out[i];
  end
endmodule // mfp_far_end

// ==== dv/test_mfp_pin_map.sv ====
// Self-checking bench for the pin decoder: register calls, pad levels.
// Assumes mfp_far_end on the pads and the property checker bound in.
`timescale 1ns/1ns
module test_mfp_pin_map;
  import mfp_pkg::*;
  localparam logic [6:0][7:0] CTRL_CFG = 56'h12112820202020;
  logic            core_clk, f, v;
  logic            rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]      reg_addr = 8'h00, cmn = 8'h00, ch0 = 8'h00, ch1 = 8'h00, rlo = 8'h00;
  logic [7:0]      rhi = 8'h00, act = 8'h00, lck = 8'h00, mde = 8'h00;
  logic [15:0]     reg_wr_data = 16'h0000, reg_rd_data, d;
  logic [6:0]      pin_in, pin_out, oe_n, drv = 7'h00;
  logic [3:0][7:0] rsts = '0;
  logic [3:0]      ract = 4'h0, fflt, vto;
  logic            clr_c, clr0, clr1;
  int              fails = 0, tests_run = 0, cycles = 0;
  mfp_pin_map u_mfp_pin_map (
    .core_clk, .rst, .reg_addr, .reg_wr_data, .reg_wr, .reg_rd, .reg_rd_data,
    .multifunction_pin_in(pin_in), .multifunction_pin_out(pin_out),
    .multifunction_pin_oe_n(oe_n), .common_irq_events(cmn),
    .channel_0_irq_events(ch0), .channel_1_irq_events(ch1), .resync_status_lo(rlo),
    .resync_status_hi(rhi), .ref_status(rsts), .ref_active(ract),
    .digital_loop_0_active_status(act), .digital_loop_0_lock_status(lck),
    .digital_loop_0_mode_status(mde), .clear_common_irq(clr_c),
    .clear_channel_0_irq(clr0), .clear_channel_1_irq(clr1), .ref_force_fault(fflt),
    .ref_validation_timeout(vto));
  mfp_far_end u_mfp_far_end (.drv, .pin_out, .pin_oe_n(oe_n), .pad(pin_in));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Runs take about 2450 cycles; the ceiling leaves wide margin
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      final_report();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] wd);
    @(posedge core_clk);
    reg_addr    <= a;
    reg_wr_data <= wd;
    reg_wr      <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] rdv);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rdv = reg_rd_data;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Pattern and its complement flip every decoded status except the common and channel 1 event ORs
  task automatic set_src(input logic k);
    logic [7:0] m;
    m = {8{k}};
    @(posedge core_clk);
    cmn  <= 8'h10 ^ m;
    ch0  <= 8'h00 ^ m;
    ch1  <= 8'h01 ^ m;
    rlo  <= 8'h08 ^ m;
    rhi  <= 8'h80 ^ m;
    rsts <= 32'h10180800 ^ {4{m}};
    ract <= 4'h5 ^ m[3:0];
    act  <= 8'hc0 ^ m;
    lck  <= 8'h0a ^ m;
    mde  <= 8'h05 ^ m;
  endtask
  function automatic logic exp_stat(input logic [6:0] c);
    case (c) inside
      7'h11: return |cmn;
      7'h12: return |ch0;
      7'h13: return |ch1;
      7'h1c: return rlo[3];
      7'h1d: return rlo[7];
      7'h1e: return rhi[3];
      7'h1f: return rhi[7];
      [7'h20:7'h23]: return rsts[c[1:0]][3];
      [7'h24:7'h27]: return rsts[c[1:0]][4];
      [7'h28:7'h2b]: return ract[c[1:0]];
      [7'h30:7'h33]: return lck[c[2:0] + 3'd1];
      7'h34: return |act[5:0];
      [7'h35:7'h37]: return mde[c[2:0] - 3'd5];
      default: return 1'b0;
    endcase
  endfunction
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    cyc(1);
    chk({9'h000, oe_n}, 16'h007f);
    wr(8'h0c, 16'h00ff);
    rd(8'h0c, d);
    chk(d, 16'h0000);
    rd(FUNC_BASE, d);
    chk(d, {8'h00, FUNC_RST});
    for (int p = 0; p < 7; p++) wr(8'(p), 16'h0080);
    for (int k = 0; k < 2; k++) begin
      set_src(k[0]);
      for (int c = 'h11; c <= 'h37; c++) begin
        wr(FUNC_BASE, {9'h001, c[6:0]});
        wr(8'(c % 7), {9'h001, c[6:0]});
        cyc(2);
        chk({15'h0, pin_out[0]}, {15'h0, exp_stat(c[6:0])});
        chk({15'h0, pin_out[c % 7]}, {15'h0, exp_stat(c[6:0])});
      end
    end
    chk({9'h000, oe_n}, 16'h0000);
    rd(FUNC_BASE, d);
    chk(d, 16'h00b7);
    for (int p = 0; p < 7; p++) wr(8'(p), {8'h00, CTRL_CFG[p]});
    wr(BOOL_OFS, 16'h00e4);
    for (int i = 0; i < 256; i++) begin
      @(posedge core_clk);
      drv        <= i[6:0];
      rsts[0][3] <= i[7];
      cyc(4);
      f = (i[2] | !i[3]) & i[0] & !i[1];
      v = i[4] & i[7];
      chk({12'h000, fflt}, {15'h0, f});
      chk({12'h000, vto}, {15'h0, v});
      chk({13'h0, clr1, clr0, clr_c}, {14'h0, i[6], i[5]});
      rd(CTRL_OFS, d);
      chk(d, {8'h00, v, 3'h0, f, 1'b0, i[6], i[5]});
    end
    // Second pass reaches channel 1 clear and the last reference slots
    wr(8'h04, 16'h002b);
    wr(8'h05, 16'h0013);
    wr(8'h06, 16'h0023);
    rd(BOOL_OFS, d);
    chk(d, 16'h00e4);
    for (int i = 0; i < 16; i++) begin
      @(posedge core_clk);
      drv        <= {i[1], i[0], i[2], 4'h0};
      rsts[3][3] <= i[3];
      cyc(4);
      chk({12'h000, fflt}, {12'h000, i[1], 3'h0});
      chk({12'h000, vto}, {12'h000, i[2] & i[3], 3'h0});
      chk({13'h0, clr1, clr0, clr_c}, {13'h0, i[0], 2'h0});
      chk({9'h000, pin_out}, 16'h0000);
      rd(PIN_OFS, d);
      chk(d, {9'h000, i[1], i[0], i[2], 4'h0});
    end
    rd(STAT_OFS, d);
    chk(d, 16'h0000);
    final_report();
  end
endmodule // test_mfp_pin_map
